// ### logic/cmsr_core_regs.sv
/*
 * Core module status and interrupt register bank: position status,
 * oscillator lock, SDRAM configuration and the IRQ and FIQ
 * controllers, reached over an AXI4-Lite slave port.
 * Assumes one clock, synchronous board inputs and a master that
 * issues only full-word accesses.
 */
`timescale 1ns/100ps
`include "cmsr_map.svh"

module cmsr_core_regs (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// AXI4-Lite write address
	input  wire logic [31:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	// AXI4-Lite read data
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Board status inputs
	input  wire logic [1:0]                stack_position,
	input  wire logic                      stack_position_valid,
	input  wire logic                      presence_copy_done,
	// Debug comms request levels
	input  wire logic                      debug_comms_transmit,
	input  wire logic                      debug_comms_receive,
	// Oscillator and SDRAM controller side
	output logic                           oscillator_unlocked,
	output logic                           mode_update,
	output cmsr_pkg::cmsr_sdram_cfg_t      sdram_cfg,
	// Processor interrupt requests
	output logic                           irq_req,
	output logic                           fiq_req
);

	// Write channel holding state
	cmsr_pkg::cmsr_phase_t wr_phase;
	logic                  aw_held;
	logic [31:0]           aw_addr;
	logic                  w_held;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  wr_fire;
	logic                  wr_ok;
	cmsr_pkg::cmsr_reg_t   wr_sel;

	// Read channel state
	cmsr_pkg::cmsr_phase_t rd_phase;
	logic                  rd_take;
	cmsr_pkg::cmsr_reg_t   rd_sel;
	logic [31:0]           rd_word;

	// Register write strobes
	logic                  we_lock;
	logic                  we_sdram;
	logic                  we_irq_set;
	logic                  we_irq_clr;
	logic                  we_fiq_set;
	logic                  we_fiq_clr;
	logic                  we_soft_set;
	logic                  we_soft_clr;

	// Register state
	logic [15:0]           lock_key;
	logic                  locked;
	logic                  soft_int;
	logic [2:0]            raw_src;
	logic [2:0]            irq_enable;
	logic [2:0]            irq_masked;
	logic [2:0]            fiq_enable;
	logic [2:0]            fiq_masked;
	logic [7:0]            position_id;

	// Address and data channels are ready while their slot is empty and no write response is pending
	assign s_axi_awready = !aw_held && (wr_phase == cmsr_pkg::ph_open);
	assign s_axi_wready  = !w_held && (wr_phase == cmsr_pkg::ph_open);

	// Write address slot; either channel may arrive first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// Write data slot
	always_ff @(posedge clk) begin
		if (!resetn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// A write commits once both halves are held
	assign wr_fire = aw_held && w_held
		&& (wr_phase == cmsr_pkg::ph_open);
	assign wr_sel  = cmsr_pkg::cmsr_decode(aw_addr);

	// Partial strobes are refused whole rather than merged
	assign wr_ok = wr_fire && (wr_sel != cmsr_pkg::reg_none)
		&& (w_strb == `CMSR_STRB_FULL);

	// Write response phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_phase     <= cmsr_pkg::ph_open;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CMSR_RESP_OKAY;
		end else begin
			unique case (wr_phase)
				cmsr_pkg::ph_open: begin
					if (wr_fire) begin
						wr_phase     <= cmsr_pkg::ph_respond;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_ok ? `CMSR_RESP_OKAY
							: `CMSR_RESP_SLVERR;
					end
				end
				cmsr_pkg::ph_respond: begin
					if (s_axi_bready) begin
						wr_phase     <= cmsr_pkg::ph_open;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// Per-register write strobes, one cycle each
	assign we_lock     = wr_ok && (wr_sel == cmsr_pkg::reg_lock);
	assign we_sdram    = wr_ok && (wr_sel == cmsr_pkg::reg_sdram);
	assign we_irq_set  = wr_ok && (wr_sel == cmsr_pkg::reg_irq_en_set);
	assign we_irq_clr  = wr_ok && (wr_sel == cmsr_pkg::reg_irq_enclr);
	assign we_fiq_set  = wr_ok && (wr_sel == cmsr_pkg::reg_fiq_en_set);
	assign we_fiq_clr  = wr_ok && (wr_sel == cmsr_pkg::reg_fiq_enclr);
	assign we_soft_set = wr_ok && (wr_sel == cmsr_pkg::reg_soft_set);
	assign we_soft_clr = wr_ok && (wr_sel == cmsr_pkg::reg_soft_clr);

	// Oscillator lock key and flag
	cmsr_lock_guard u_lock (
		.clk       (clk),
		.resetn    (resetn),
		.key_we    (we_lock),
		.key_wdata (w_data[15:0]),
		.lock_key  (lock_key),
		.locked    (locked)
	);

	// Writes to the oscillator settings are let through only if open
	assign oscillator_unlocked = !locked;

	// SDRAM geometry, size and latency; reserved codes are stored as
	// written since the controller owns what they mean
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sdram_cfg.bank_count            <= `CMSR_SD_GEOM_RST;
			sdram_cfg.column_count          <= `CMSR_SD_GEOM_RST;
			sdram_cfg.row_count             <= `CMSR_SD_GEOM_RST;
			sdram_cfg.sdram_size            <= `CMSR_SD_SIZE_RST;
			sdram_cfg.column_access_latency <= `CMSR_SD_CAS_RST;
		end else if (we_sdram) begin
			sdram_cfg.bank_count   <=
				w_data[`CMSR_SD_BANK_LSB +: 4];
			sdram_cfg.column_count <=
				w_data[`CMSR_SD_COL_LSB +: 4];
			sdram_cfg.row_count    <=
				w_data[`CMSR_SD_ROW_LSB +: 4];
			sdram_cfg.sdram_size   <=
				w_data[`CMSR_SD_SIZE_LSB +: 3];
			sdram_cfg.column_access_latency <=
				w_data[`CMSR_SD_CAS_LSB +: 2];
		end
	end

	// Mode update pulse lines up with the new parameters on sdram_cfg
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_update <= 1'b0;
		end else begin
			mode_update <= we_sdram;
		end
	end

	// Software interrupt bit; set and clear come from separate writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			soft_int <= 1'b0;
		end else if (we_soft_set && w_data[0]) begin
			soft_int <= 1'b1;
		end else if (we_soft_clr && w_data[0]) begin
			soft_int <= 1'b0;
		end
	end

	// Raw sources are live levels, not latched
	always_comb begin
		raw_src                 = 3'h0;
		raw_src[`CMSR_SRC_TX]   = debug_comms_transmit;
		raw_src[`CMSR_SRC_RX]   = debug_comms_receive;
		raw_src[`CMSR_SRC_SOFT] = soft_int;
	end

	// Normal interrupt controller
	cmsr_irq_ctrl u_irq (
		.clk    (clk),
		.resetn (resetn),
		.raw    (raw_src),
		.set_we (we_irq_set),
		.clr_we (we_irq_clr),
		.wbits  (w_data[2:0]),
		.enable (irq_enable),
		.masked (irq_masked),
		.req    (irq_req)
	);

	// Fast interrupt controller, independent enables
	cmsr_irq_ctrl u_fiq (
		.clk    (clk),
		.resetn (resetn),
		.raw    (raw_src),
		.set_we (we_fiq_set),
		.clr_we (we_fiq_clr),
		.wbits  (w_data[2:0]),
		.enable (fiq_enable),
		.masked (fiq_masked),
		.req    (fiq_req)
	);

	// Stack position, with a fixed marker when it cannot be trusted
	assign position_id = stack_position_valid
		? {6'h00, stack_position} : `CMSR_STAT_POS_BAD;

	// Read multiplexer; reserved bits answer zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (rd_sel)
			cmsr_pkg::reg_position: begin
				rd_word[7:0]   = position_id;
				rd_word[23:16] = `CMSR_STAT_SRAM_SIZE;
			end
			cmsr_pkg::reg_lock: begin
				rd_word[15:0]  = lock_key;
				rd_word[`CMSR_LOCK_FLAG_BIT] = locked;
			end
			cmsr_pkg::reg_sdram: begin
				rd_word[`CMSR_SD_BANK_LSB +: 4] = sdram_cfg.bank_count;
				rd_word[`CMSR_SD_COL_LSB +: 4]  = sdram_cfg.column_count;
				rd_word[`CMSR_SD_ROW_LSB +: 4]  = sdram_cfg.row_count;
				rd_word[`CMSR_SD_DONE_BIT] = presence_copy_done;
				rd_word[`CMSR_SD_SIZE_LSB +: 3] = sdram_cfg.sdram_size;
				rd_word[`CMSR_SD_CAS_LSB +: 2]  =
					sdram_cfg.column_access_latency;
			end
			cmsr_pkg::reg_irq_stat:  rd_word[2:0] = irq_masked;
			cmsr_pkg::reg_irq_raw:   rd_word[2:0] = raw_src;
			cmsr_pkg::reg_irq_en_set: rd_word[2:0] = irq_enable;
			cmsr_pkg::reg_soft_set:  rd_word[0]   = soft_int;
			cmsr_pkg::reg_fiq_stat:  rd_word[2:0] = fiq_masked;
			cmsr_pkg::reg_fiq_raw:   rd_word[2:0] = raw_src;
			cmsr_pkg::reg_fiq_en_set: rd_word[2:0] = fiq_enable;
			cmsr_pkg::reg_irq_enclr,
			cmsr_pkg::reg_fiq_enclr,
			cmsr_pkg::reg_soft_clr,
			cmsr_pkg::reg_none: rd_word = 32'h0000_0000;
		endcase
	end

	// One read in flight; a new address waits until data is taken
	assign s_axi_arready = (rd_phase == cmsr_pkg::ph_open);
	assign rd_take       = s_axi_arvalid && s_axi_arready;
	assign rd_sel        = cmsr_pkg::cmsr_decode(s_axi_araddr);

	// Read data is captured at the address edge so it stays stable
	// while the master stalls rready
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_phase     <= cmsr_pkg::ph_open;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CMSR_RESP_OKAY;
		end else begin
			unique case (rd_phase)
				cmsr_pkg::ph_open: begin
					if (rd_take) begin
						rd_phase     <= cmsr_pkg::ph_respond;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata  <= rd_word;
						s_axi_rresp  <= (rd_sel == cmsr_pkg::reg_none)
							? `CMSR_RESP_SLVERR : `CMSR_RESP_OKAY;
					end
				end
				cmsr_pkg::ph_respond: begin
					if (s_axi_rready) begin
						rd_phase     <= cmsr_pkg::ph_open;
						s_axi_rvalid <= 1'b0;
					end
				end
			endcase
		end
	end

endmodule

// ### logic/cmsr_irq_ctrl.sv
/*
 * One three-source interrupt controller: enable register with set
 * and clear locations, masked status and a request output.
 * Assumes set and clear writes never arrive in the same cycle.
 */
`timescale 1ns/100ps

module cmsr_irq_ctrl (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Request levels
	input  wire logic [2:0] raw,
	// Enable writes
	input  wire logic       set_we,
	input  wire logic       clr_we,
	input  wire logic [2:0] wbits,
	// State and request
	output logic      [2:0] enable,
	output logic      [2:0] masked,
	output logic            req
);

	// Enable bits: ones set or clear, zeros leave alone
	always_ff @(posedge clk) begin
		if (!resetn) begin
			enable <= 3'h0;
		end else if (set_we) begin
			enable <= enable | wbits;
		end else if (clr_we) begin
			enable <= enable & ~wbits;
		end
	end

	// Masked view of the live request levels
	assign masked = raw & enable;

	// Registered so the processor sees a glitch-free request
	always_ff @(posedge clk) begin
		if (!resetn) begin
			req <= 1'b0;
		end else begin
			req <= |masked;
		end
	end

endmodule

// ### logic/cmsr_lock_guard.sv
/*
 * Oscillator write lock: holds the last key written and the locked
 * flag that gates writes to the oscillator settings register.
 * Assumes word writes strobed by the register bank.
 */
`timescale 1ns/100ps
`include "cmsr_map.svh"

module cmsr_lock_guard (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Key write
	input  wire logic        key_we,
	input  wire logic [15:0] key_wdata,
	// State
	output logic      [15:0] lock_key,
	output logic             locked
);

	// Key field reads back what was last written
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lock_key <= `CMSR_LOCK_KEY_RST;
		end else if (key_we) begin
			lock_key <= key_wdata;
		end
	end

	// Only the exact key opens; anything else closes again
	always_ff @(posedge clk) begin
		if (!resetn) begin
			locked <= 1'b1;
		end else if (key_we) begin
			locked <= (key_wdata != `CMSR_LOCK_KEY);
		end
	end

endmodule

// ### logic/cmsr_map.svh
/*
 * Register map of the core module status and interrupt register bank:
 * byte addresses, field positions, reset values and bus answer codes.
 * Assumes inclusion by the package, the design files and the bench files.
 */
`ifndef CMSR_MAP_SVH
`define CMSR_MAP_SVH

// Byte addresses on the register bus
`define CMSR_OFF_POSITION   32'h1000_0010
`define CMSR_OFF_LOCK       32'h1000_0014
`define CMSR_OFF_SDRAM      32'h1000_0020
`define CMSR_OFF_IRQ_STAT   32'h1000_0040
`define CMSR_OFF_IRQ_RAW    32'h1000_0044
`define CMSR_OFF_IRQ_EN_SET 32'h1000_0048
`define CMSR_OFF_IRQ_ENCLR  32'h1000_004c
`define CMSR_OFF_SOFT_SET   32'h1000_0050
`define CMSR_OFF_SOFT_CLR   32'h1000_0054
`define CMSR_OFF_FIQ_STAT   32'h1000_0060
`define CMSR_OFF_FIQ_RAW    32'h1000_0064
`define CMSR_OFF_FIQ_EN_SET 32'h1000_0068
`define CMSR_OFF_FIQ_ENCLR  32'h1000_006c

// Module position status word
`define CMSR_STAT_SRAM_SIZE 8'h04
`define CMSR_STAT_POS_BAD   8'hff

// Oscillator write lock word
`define CMSR_LOCK_KEY       16'ha05f
`define CMSR_LOCK_KEY_RST   16'h0000
`define CMSR_LOCK_FLAG_BIT  16

// SDRAM configuration and status word
`define CMSR_SD_BANK_LSB    16
`define CMSR_SD_COL_LSB     12
`define CMSR_SD_ROW_LSB     8
`define CMSR_SD_DONE_BIT    5
`define CMSR_SD_SIZE_LSB    2
`define CMSR_SD_CAS_LSB     0
`define CMSR_SD_GEOM_RST    4'h0
`define CMSR_SD_SIZE_RST    3'h2
`define CMSR_SD_CAS_RST     2'h2

// Interrupt source positions
`define CMSR_SRC_TX         2
`define CMSR_SRC_RX         1
`define CMSR_SRC_SOFT       0

// Bus answers
`define CMSR_RESP_OKAY      2'h0
`define CMSR_RESP_SLVERR    2'h2
`define CMSR_STRB_FULL      4'hf

`endif

// ### logic/cmsr_pkg.sv
/*
 * Types shared by the register bank: register selector, SDRAM
 * configuration carrier, bus state codes and the address decoder.
 * Assumes the map header is on the include path.
 */
package cmsr_pkg;
`include "cmsr_map.svh"

	// Which register an address selects
	typedef enum logic [3:0] {
		reg_none      = 4'b0000,
		reg_position  = 4'b0001,
		reg_lock      = 4'b0010,
		reg_sdram     = 4'b0011,
		reg_irq_stat  = 4'b0100,
		reg_irq_raw   = 4'b0101,
		reg_irq_en_set = 4'b0110,
		reg_irq_enclr = 4'b0111,
		reg_soft_set  = 4'b1000,
		reg_soft_clr  = 4'b1001,
		reg_fiq_stat  = 4'b1010,
		reg_fiq_raw   = 4'b1011,
		reg_fiq_en_set = 4'b1100,
		reg_fiq_enclr = 4'b1101
	} cmsr_reg_t;

	// Bus channel phase
	typedef enum logic {
		ph_open    = 1'b0,
		ph_respond = 1'b1
	} cmsr_phase_t;

	// SDRAM parameters handed to the memory controller
	typedef struct packed {
		logic [3:0] bank_count;
		logic [3:0] column_count;
		logic [3:0] row_count;
		logic [2:0] sdram_size;
		logic [1:0] column_access_latency;
	} cmsr_sdram_cfg_t;

	// Byte address to register selector
	function automatic cmsr_reg_t cmsr_decode(input logic [31:0] addr);
		unique case (addr)
			`CMSR_OFF_POSITION:  cmsr_decode = reg_position;
			`CMSR_OFF_LOCK:      cmsr_decode = reg_lock;
			`CMSR_OFF_SDRAM:     cmsr_decode = reg_sdram;
			`CMSR_OFF_IRQ_STAT:  cmsr_decode = reg_irq_stat;
			`CMSR_OFF_IRQ_RAW:   cmsr_decode = reg_irq_raw;
			`CMSR_OFF_IRQ_EN_SET: cmsr_decode = reg_irq_en_set;
			`CMSR_OFF_IRQ_ENCLR: cmsr_decode = reg_irq_enclr;
			`CMSR_OFF_SOFT_SET:  cmsr_decode = reg_soft_set;
			`CMSR_OFF_SOFT_CLR:  cmsr_decode = reg_soft_clr;
			`CMSR_OFF_FIQ_STAT:  cmsr_decode = reg_fiq_stat;
			`CMSR_OFF_FIQ_RAW:   cmsr_decode = reg_fiq_raw;
			`CMSR_OFF_FIQ_EN_SET: cmsr_decode = reg_fiq_en_set;
			`CMSR_OFF_FIQ_ENCLR: cmsr_decode = reg_fiq_enclr;
			default:             cmsr_decode = reg_none;
		endcase
	endfunction
endpackage

// ### tb/cmsr_axi_master.sv
/*
 * Processor side model: one word read or write at a time on the
 * register bus, answering promptly or after lag cycles.
 * Assumes the bench calls its tasks and watches the timeout flag.
 */
`timescale 1ns/100ps

module cmsr_axi_master (
	// Clock
	input  wire logic        clk,
	// Write side
	output logic      [31:0] awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic      [3:0]  wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// Read side
	output logic      [31:0] araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	int lag = 0;

	// Idle bus from time zero
	initial begin
		{awaddr, wdata, araddr, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
	end

	// Address and data offered together, each released once taken
	task automatic write_word(input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] resp, output bit to);
		int n;
		n = 0;
		to = 1'b1;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= {2'b11, lag == 0};
		while (n < 60 && to) begin
			@(posedge clk);
			// Released lines show a changed value, not the old one
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				to = 1'b0;
			end else if (n >= lag) begin
				bready <= 1'b1;
			end
			n++;
		end
	endtask

	// Read request held until taken, data taken at the ready edge
	task automatic read_word(input logic [31:0] a, output logic [31:0] d,
			output logic [1:0] resp, output bit to);
		int n;
		n = 0;
		to = 1'b1;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 1'b1, lag == 0};
		while (n < 60 && to) begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				{d, resp} = {rdata, rresp};
				rready <= 1'b0;
				to = 1'b0;
			end else if (n >= lag) begin
				rready <= 1'b1;
			end
			n++;
		end
	endtask
endmodule

// ### tb/cmsr_core_monitor.sv
/*
 * Checker for the register bank: bus answers held, SDRAM update
 * strobe, lock output and reset values.
 * Assumes binding to cmsr_core_regs with the map header on the path.
 */
`timescale 1ns/100ps
`include "cmsr_map.svh"

module cmsr_core_monitor (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      resetn,
	// Bus
	input wire logic [31:0]               s_axi_awaddr,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	// Outputs under watch
	input wire logic                      oscillator_unlocked,
	input wire logic                      mode_update,
	input wire cmsr_pkg::cmsr_sdram_cfg_t sdram_cfg,
	input wire logic                      irq_req,
	input wire logic                      fiq_req
);
	logic aw_sdram;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Target of the write in flight; the address is gone once taken
	always_ff @(posedge clk) begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_sdram <= (s_axi_awaddr == `CMSR_OFF_SDRAM);
		end
	end

	// Accepted SDRAM word write reaching its commit
	sequence sdram_commit;
		$rose(s_axi_bvalid) && aw_sdram && s_axi_bresp == `CMSR_RESP_OKAY;
	endsequence

	mode_cause_a: assert property (sdram_commit |-> ##[0:1] mode_update)
		else $error("no mode update after SDRAM write");
	mode_pulse_a: assert property (mode_update |=> !mode_update)
		else $error("mode update longer than one cycle");
	cfg_gate_a: assert property (!$stable(sdram_cfg) |-> mode_update)
		else $error("SDRAM settings changed without update");
	unlock_cause_a: assert property ($changed(oscillator_unlocked)
		|-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("lock state changed without a write");
	hold_b_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	hold_r_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	reset_out_a: assert property (disable iff (1'b0) !resetn
		|=> !irq_req && !fiq_req && !oscillator_unlocked)
		else $error("outputs not cleared by reset");
	cfg_reset_a: assert property ($rose(resetn) |-> sdram_cfg ==
		{12'h000, `CMSR_SD_SIZE_RST, `CMSR_SD_CAS_RST})
		else $error("SDRAM settings wrong after reset");
endmodule

bind cmsr_core_regs cmsr_core_monitor u_mon (.clk(clk), .resetn(resetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .oscillator_unlocked(oscillator_unlocked),
	.mode_update(mode_update), .sdram_cfg(sdram_cfg),
	.irq_req(irq_req), .fiq_req(fiq_req));

// ### tb/test_core_module_status_irq_regs.sv
/*
 * Bench for the register bank: reset values, position word, lock,
 * SDRAM word, both interrupt controllers and refused accesses.
 * Assumes the design, the checker and the bus model are compiled.
 */
`timescale 1ns/100ps
`include "cmsr_map.svh"

module test_core_module_status_irq_regs;
	localparam logic [1:0] okay = `CMSR_RESP_OKAY;
	localparam logic [1:0] slverr = `CMSR_RESP_SLVERR;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] stack_position = 2'h0;
	logic stack_position_valid = 1'b0;
	logic presence_copy_done = 1'b0;
	logic tx = 1'b0;
	logic rx = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic unlocked, mode_update, irq_req, fiq_req;
	cmsr_pkg::cmsr_sdram_cfg_t sdram_cfg;
	int miscompares = 0;
	int samples_checked = 0;

	// 10 MHz clock
	always #50 clk = ~clk;

	cmsr_axi_master host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	cmsr_core_regs dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .stack_position(stack_position),
		.stack_position_valid(stack_position_valid),
		.presence_copy_done(presence_copy_done),
		.debug_comms_transmit(tx), .debug_comms_receive(rx),
		.oscillator_unlocked(unlocked), .mode_update(mode_update),
		.sdram_cfg(sdram_cfg), .irq_req(irq_req), .fiq_req(fiq_req));

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value %s: expected %h seen %h", what, want, seen);
		end
	endtask

	// A hung transfer ends the run at once
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] want);
		logic [1:0] resp;
		bit to;
		host.write_word(a, d, s, resp, to);
		if (to) begin
			miscompares++;
			results();
		end else begin
			check("write response", {30'h0, resp}, {30'h0, want});
		end
	endtask

	task automatic rd(input string what, input logic [31:0] a,
			input logic [31:0] want, input logic [1:0] want_resp);
		logic [31:0] d;
		logic [1:0] resp;
		bit to;
		host.read_word(a, d, resp, to);
		if (to) begin
			miscompares++;
			results();
		end else begin
			check(what, d, want);
			check("read response", {30'h0, resp}, {30'h0, want_resp});
		end
	endtask

	// Main sequence; outputs are checked after a read so they have settled
	initial begin
		int c;
		logic [31:0] b;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd("sdram", `CMSR_OFF_SDRAM, 32'h0000_000a, okay);
		rd("lock", `CMSR_OFF_LOCK, 32'h0001_0000, okay);
		rd("enables", `CMSR_OFF_FIQ_EN_SET, 32'h0000_0000, okay);
		rd("soft", `CMSR_OFF_SOFT_SET, 32'h0000_0000, okay);
		for (c = 0; c < 5; c++) begin
			@(posedge clk);
			stack_position <= c[1:0];
			stack_position_valid <= (c < 4);
			rd("position", `CMSR_OFF_POSITION,
				{16'h0004, 8'h00, (c < 4) ? c[7:0] : 8'hff}, okay);
		end
		wr(`CMSR_OFF_POSITION, 32'h0000_0001, 4'hf, okay);
		rd("position", `CMSR_OFF_POSITION, 32'h0004_00ff, okay);
		// Slow master through the lock sequence
		host.lag = 3;
		wr(`CMSR_OFF_LOCK, 32'h0000_a05f, 4'hf, okay);
		rd("lock", `CMSR_OFF_LOCK, 32'h0000_a05f, okay);
		check("unlocked", {31'h0, unlocked}, 32'h0000_0001);
		wr(`CMSR_OFF_LOCK, 32'h0000_a05e, 4'hf, okay);
		rd("lock", `CMSR_OFF_LOCK, 32'h0001_a05e, okay);
		check("unlocked", {31'h0, unlocked}, 32'h0000_0000);
		host.lag = 0;
		wr(`CMSR_OFF_SDRAM, 32'h000a_b93f, 4'hf, okay);
		rd("sdram", `CMSR_OFF_SDRAM, 32'h000a_b91f, okay);
		check("cfg", {15'h0, sdram_cfg},
			{15'h0, 4'ha, 4'hb, 4'h9, 3'h7, 2'h3});
		@(posedge clk);
		presence_copy_done <= 1'b1;
		for (c = 0; c < 5; c++) begin
			wr(`CMSR_OFF_SDRAM, {27'h0, c[2:0], 2'h2}, 4'hf, okay);
			rd("size", `CMSR_OFF_SDRAM,
				{26'h0, 1'b1, c[2:0], 2'h2}, okay);
		end
		@(posedge clk);
		tx <= 1'b1;
		rd("raw", `CMSR_OFF_IRQ_RAW, 32'h0000_0004, okay);
		@(posedge clk);
		{tx, rx} <= 2'b11;
		// Same walk on the normal, then the fast controller
		for (c = 0; c < 2; c++) begin
			b = `CMSR_OFF_IRQ_STAT + 32'h0000_0020 * c;
			rd("raw", b + 32'h4, 32'h0000_0006, okay);
			rd("masked", b, 32'h0000_0000, okay);
			wr(b + 32'h8, 32'h0000_0006, 4'hf, okay);
			wr(b + 32'h8, 32'h0000_0001, 4'hf, okay);
			rd("enables", b + 32'h8, 32'h0000_0007, okay);
			rd("masked", b, 32'h0000_0006, okay);
			check("req", {30'h0, fiq_req, irq_req}, 32'h1 << c);
			wr(`CMSR_OFF_SOFT_SET, 32'h0000_0001, 4'hf, okay);
			rd("soft", `CMSR_OFF_SOFT_SET, 32'h0000_0001, okay);
			rd("raw", b + 32'h4, 32'h0000_0007, okay);
			wr(b + 32'hc, 32'h0000_0006, 4'hf, okay);
			rd("masked", b, 32'h0000_0001, okay);
			check("req", {30'h0, fiq_req, irq_req}, 32'h1 << c);
			wr(`CMSR_OFF_SOFT_CLR, 32'h0000_0001, 4'hf, okay);
			rd("masked", b, 32'h0000_0000, okay);
			check("req", {30'h0, fiq_req, irq_req}, 32'h0000_0000);
			wr(b + 32'hc, 32'h0000_0001, 4'hf, okay);
			rd("enables", b + 32'h8, 32'h0000_0000, okay);
		end
		// Refused accesses leave state alone
		rd("unmapped", 32'h1000_0018, 32'h0000_0000, slverr);
		wr(`CMSR_OFF_IRQ_EN_SET, 32'h0000_0007, 4'h1, slverr);
		rd("enables", `CMSR_OFF_IRQ_EN_SET, 32'h0000_0000, okay);
		results();
	end
endmodule
